// *** tbt_timer_pair.v ***
// even/odd type b timer pair with control registers on an axi4-lite slave
//
// Functional notes
// - timer runs only while its on bit 15 is set.
// - stop-in-idle bit 13 set halts timer in idle; clear keeps counting.
// - with external clock the gate bit is ignored and reads zero.
// - internal clock and gate bit set: count only while gate input active.
// - prescale bits 6..4 select 1:1,2,4,8,16,32,64,256.
// - pairing bit 3 exists only on the even timer.
// - paired mode: odd on, gate, prescale, source ignored; even settings rule.
// - clock source bit 1 picks external pin when set, internal clock otherwise.
// - unimplemented bits ignore writes and read zero; implemented bits reset zero.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "tbt_map.vh"
module tbt_timer_pair
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        idle_mode,
    input  wire        even_gate_in,
    input  wire        odd_gate_in,
    input  wire        even_ext_clk_pin,
    input  wire        odd_ext_clk_pin,
    output wire [15:0] even_count,
    output wire [15:0] odd_count
);

    // ------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------
    reg  [31:0] even_ctrl_r;
    reg  [31:0] odd_ctrl_r;
    reg  [7:0]  awaddr_r;
    reg         aw_held_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         w_held_r;
    reg         bvalid_r;
    reg  [1:0]  bresp_r;
    reg         rvalid_r;
    reg  [1:0]  rresp_r;
    reg  [31:0] rdata_r;
    reg  [31:0] rdata_nxt;
    reg         rd_ok;
    wire [31:0] wmask;
    wire        do_write;

    // address and data are latched independently, in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wmask    = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    // write channel capture and response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `TBT_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (awaddr_r == `TBT_EVEN_CTRL_OFS || awaddr_r == `TBT_ODD_CTRL_OFS)
                             ? `TBT_RESP_OKAY : `TBT_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // control registers; only implemented bits take writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            even_ctrl_r <= `TBT_CTRL_RESET;
            odd_ctrl_r  <= `TBT_CTRL_RESET;
        end
        else if (do_write)
        begin
            if (awaddr_r == `TBT_EVEN_CTRL_OFS)
                even_ctrl_r <= ((even_ctrl_r & ~wmask) | (wdata_r & wmask))
                               & `TBT_EVEN_MASK;
            if (awaddr_r == `TBT_ODD_CTRL_OFS)
                odd_ctrl_r <= ((odd_ctrl_r & ~wmask) | (wdata_r & wmask))
                              & `TBT_ODD_MASK;
        end
    end

    // gate bit reads zero while the external clock is selected
    function [31:0] ctrl_view;
        input [31:0] c;
        begin
            ctrl_view = c;
            if (c[`TBT_CS_BIT])
                ctrl_view[`TBT_GATE_BIT] = 1'b0;
        end
    endfunction

    // read decode
    always @*
    begin
        rd_ok     = 1'b1;
        rdata_nxt = 32'h00000000;
        case (s_axi_araddr)
            `TBT_EVEN_CTRL_OFS:  rdata_nxt = ctrl_view(even_ctrl_r);
            `TBT_ODD_CTRL_OFS:   rdata_nxt = ctrl_view(odd_ctrl_r);
            `TBT_EVEN_COUNT_OFS: rdata_nxt = {16'h0000, even_count};
            `TBT_ODD_COUNT_OFS:  rdata_nxt = {16'h0000, odd_count};
            default:             rd_ok     = 1'b0;
        endcase
    end

    // read answer one cycle after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= `TBT_RESP_OKAY;
            rdata_r  <= 32'h00000000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_ok ? `TBT_RESP_OKAY : `TBT_RESP_SLVERR;
            rdata_r  <= rdata_nxt;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // timer control
    // ------------------------------------------------------------
    wire        pair_mode;
    reg         even_ext_d_r;
    reg         odd_ext_d_r;
    wire        even_ext_rise;
    wire        odd_ext_rise;
    wire        even_run;
    wire        odd_run;
    wire        odd_on;
    wire        odd_cs;
    wire        odd_gate_en;
    wire [2:0]  odd_ps;
    wire        odd_gate_src;
    wire        odd_ext_src;
    wire        even_tick;
    wire        odd_tick;
    wire        even_ps_tick;
    wire        odd_ps_tick;
    wire        even_carry;
    wire        odd_inc;

    assign pair_mode = even_ctrl_r[`TBT_PAIR_BIT];

    // edge detect of the external clock pins; pins are already synchronous
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            even_ext_d_r <= 1'b0;
            odd_ext_d_r  <= 1'b0;
        end
        else
        begin
            even_ext_d_r <= even_ext_clk_pin;
            odd_ext_d_r  <= odd_ext_clk_pin;
        end
    end
    assign even_ext_rise = even_ext_clk_pin && !even_ext_d_r;
    assign odd_ext_rise  = odd_ext_clk_pin && !odd_ext_d_r;

    // in pair mode the odd half borrows every setting; for stop-in-idle its own bit also counts
    assign odd_on       = pair_mode ? even_ctrl_r[`TBT_ON_BIT] : odd_ctrl_r[`TBT_ON_BIT];
    assign odd_cs       = pair_mode ? even_ctrl_r[`TBT_CS_BIT] : odd_ctrl_r[`TBT_CS_BIT];
    assign odd_gate_en  = pair_mode ? even_ctrl_r[`TBT_GATE_BIT]
                                    : odd_ctrl_r[`TBT_GATE_BIT];
    assign odd_ps       = pair_mode ? even_ctrl_r[`TBT_PS_HI:`TBT_PS_LO]
                                    : odd_ctrl_r[`TBT_PS_HI:`TBT_PS_LO];
    assign odd_gate_src = pair_mode ? even_gate_in : odd_gate_in;
    assign odd_ext_src  = pair_mode ? even_ext_rise : odd_ext_rise;

    // input tick: external pin edge or every internal clock
    assign even_tick = even_ctrl_r[`TBT_CS_BIT] ? even_ext_rise : 1'b1;
    assign odd_tick  = odd_cs ? odd_ext_src : 1'b1;

    // enable, idle halt and gate; gate only matters on the internal clock
    assign even_run = even_ctrl_r[`TBT_ON_BIT]
                   && !(idle_mode && even_ctrl_r[`TBT_STOP_IDLE_BIT])
                   && (even_ctrl_r[`TBT_CS_BIT] || !even_ctrl_r[`TBT_GATE_BIT]
                       || even_gate_in);
    // high half of a paired timer also stops in idle if odd stop-in-idle is left set; the even low half counts on
    assign odd_run  = odd_on
                   && !(idle_mode && odd_ctrl_r[`TBT_STOP_IDLE_BIT])
                   && !(pair_mode && idle_mode && even_ctrl_r[`TBT_STOP_IDLE_BIT])
                   && (odd_cs || !odd_gate_en || odd_gate_src);

    // prescalers; odd one idles in pair mode since the carry drives it
    tbt_prescaler u_even_ps
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (!even_ctrl_r[`TBT_ON_BIT]),
        .tick_in  (even_tick && even_run),
        .ps_sel   (even_ctrl_r[`TBT_PS_HI:`TBT_PS_LO]),
        .tick_out (even_ps_tick)
    );

    tbt_prescaler u_odd_ps
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (!odd_on || pair_mode),
        .tick_in  (odd_tick && odd_run),
        .ps_sel   (odd_ps),
        .tick_out (odd_ps_tick)
    );

    // low half counts prescaler pulses; high half takes the carry when paired
    assign odd_inc = pair_mode ? (even_carry && odd_run) : odd_ps_tick;

    tbt_counter #(.W(16)) u_even_cnt
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (1'b0),
        .inc     (even_ps_tick),
        .count   (even_count),
        .carry   (even_carry)
    );

    tbt_counter #(.W(16)) u_odd_cnt
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (1'b0),
        .inc     (odd_inc),
        .count   (odd_count),
        .carry   ()
    );

endmodule

// *** tbt_map.vh ***
// register offsets, field positions and reset values of the paired timer block
`ifndef TBT_MAP_VH
`define TBT_MAP_VH

// byte offsets on the register bus
`define TBT_EVEN_CTRL_OFS   8'h00
`define TBT_EVEN_COUNT_OFS  8'h04
`define TBT_ODD_CTRL_OFS    8'h08
`define TBT_ODD_COUNT_OFS   8'h0c

// control register fields
`define TBT_ON_BIT          15
`define TBT_STOP_IDLE_BIT   13
`define TBT_GATE_BIT        7
`define TBT_PS_HI           6
`define TBT_PS_LO           4
`define TBT_PAIR_BIT        3
`define TBT_CS_BIT          1

// writable bit masks: even timer has the pairing bit, odd does not
`define TBT_EVEN_MASK       32'h0000a0fa
`define TBT_ODD_MASK        32'h0000a0f2
`define TBT_CTRL_RESET      32'h00000000
`define TBT_COUNT_RESET     16'h0000

// axi response codes
`define TBT_RESP_OKAY       2'b00
`define TBT_RESP_SLVERR     2'b10

`endif

// *** tbt_prescaler.v ***
// input prescaler: one pulse out per 1,2,4,8,16,32,64 or 256 input ticks
`timescale 1ns/1ns
module tbt_prescaler
(
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       clear,
    input  wire       tick_in,
    input  wire [2:0] ps_sel,
    output wire       tick_out
);

    reg  [7:0] div_cnt_r;
    reg  [7:0] div_lim;

    // terminal count per select code
    always @*
    begin
        case (ps_sel)
            3'h0:    div_lim = 8'h00;
            3'h1:    div_lim = 8'h01;
            3'h2:    div_lim = 8'h03;
            3'h3:    div_lim = 8'h07;
            3'h4:    div_lim = 8'h0f;
            3'h5:    div_lim = 8'h1f;
            3'h6:    div_lim = 8'h3f;
            default: div_lim = 8'hff; // 1:256, not 1:128
        endcase
    end

    assign tick_out = tick_in && (div_cnt_r >= div_lim);

    // counter restarts whenever the timer is off so the first period is full
    always @(posedge aclk)
    begin
        if (!aresetn || clear)
            div_cnt_r <= 8'h00;
        else if (tick_in)
            div_cnt_r <= (div_cnt_r >= div_lim) ? 8'h00 : div_cnt_r + 8'h01;
    end

endmodule

// *** tbt_counter.v ***
// 16-bit timer half with synchronous clear
`timescale 1ns/1ns
module tbt_counter
#(
    parameter W = 16
)
(
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         clear,
    input  wire         inc,
    output wire [W-1:0] count,
    output wire         carry
);

    reg  [W-1:0] count_r;

    assign count = count_r;
    // wraps on the increment that passes all ones
    assign carry = inc && (&count_r);

    always @(posedge aclk)
    begin
        if (!aresetn || clear)
            count_r <= {W{1'b0}};
        else if (inc)
            count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
    end

endmodule

// *** tbt_timer_pair_props.sv ***
// port assertions for the type b timer pair
`timescale 1ns/1ns
module tbt_timer_pair_props
(
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [15:0] even_count,
    input logic [15:0] odd_count
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ----------------------------------------
    // bus handshakes
    // ----------------------------------------
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_take |-> ##2 s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    // one transfer of each kind at a time, so a pending answer blocks new requests
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_rd_high;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_b_done: assert property (p_b_done) else $error("write answer stuck");
    a_r_done: assert property (p_r_done) else $error("read answer stuck");
    a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
    a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
    a_rd_high: assert property (p_rd_high) else $error("upper read bits set");

    // ----------------------------------------
    // counters
    // ----------------------------------------
    // past reset guard: a sync reset may zero the count one edge late
    property p_even_step;
        $past(aresetn) && $changed(even_count) |-> even_count == $past(even_count) + 16'h0001;
    endproperty
    property p_odd_step;
        $past(aresetn) && $changed(odd_count) |-> odd_count == $past(odd_count) + 16'h0001;
    endproperty
    a_even_step: assert property (p_even_step) else $error("even count jumped");
    a_odd_step: assert property (p_odd_step) else $error("odd count jumped");
endmodule

bind tbt_timer_pair tbt_timer_pair_props u_tbt_timer_pair_props
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .even_count(even_count), .odd_count(odd_count)
);

// *** tbt_timer_pair_bench.sv ***
// self-checking bench for the type b timer pair
`timescale 1ns/1ns
`include "tbt_map.vh"
module tbt_timer_pair_bench;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic        idle = 1'h0, eg = 1'h0, og = 1'h0, ep = 1'h0, op = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, v, e;
    logic [15:0] ec, oc, c0, o0;
    logic [16:0] lfsr = 17'h107d1;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    int          n_mismatch = 0, n_tests = 0, i, k;

    tbt_timer_pair u_tbt_timer_pair
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .idle_mode(idle), .even_gate_in(eg), .odd_gate_in(og), .even_ext_clk_pin(ep),
        .odd_ext_clk_pin(op), .even_count(ec), .odd_count(oc)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial
    begin
        forever #5 aclk = ~aclk;
    end

    task stop_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [33:0] s, input logic [33:0] x);
        n_tests++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask

    // a used-up wait bound counts as a mismatch and ends the run
    task fail;
        n_mismatch++;
        stop_test;
    endtask

    // random source: 17-bit shift register, taps 17 and 14
    function automatic logic [16:0] lfsr_step(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (k == 50) fail;
    endtask

    task rd(input logic [7:0] a, input logic [33:0] x);
        exp_r.push_back(x);
        araddr <= a;
        arvalid <= 1'h1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (k == 50) fail;
    endtask

    // advance of the even count over n edges, after a short settle
    task span(input int n, input logic [15:0] inc);
        repeat (3) @(posedge aclk);
        c0 = ec;
        repeat (n) @(posedge aclk);
        chk(16'(ec - c0), inc);
    endtask

    // monitor: answers are matched against the oldest note
    always @(posedge aclk)
    begin
        if (aresetn && bvalid) chk(bresp, exp_b.pop_front());
        if (aresetn && rvalid) chk({rresp, rdata}, exp_r.pop_front());
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 4; i++) rd(8'(i * 4), 34'h0);
        rd(8'h10, {`TBT_RESP_SLVERR, 32'h0});
        wr(8'h10, 32'hffffffff, `TBT_RESP_SLVERR);
        wr(`TBT_EVEN_CTRL_OFS, 32'hffffffff, 2'h0);
        rd(`TBT_EVEN_CTRL_OFS, 34'h0a07a);
        wr(`TBT_EVEN_CTRL_OFS, 32'h00000080, 2'h0);
        rd(`TBT_EVEN_CTRL_OFS, 34'h00080);
        $display("test register access done");
        // random odd control words, gate bit hidden under external clock
        repeat (8)
        begin
            lfsr = lfsr_step(lfsr);
            v = {lfsr[14:0], lfsr};
            og <= lfsr[0];
            e = v & `TBT_ODD_MASK;
            if (e[1]) e[7] = 1'h0;
            wr(`TBT_ODD_CTRL_OFS, v, 2'h0);
            rd(`TBT_ODD_CTRL_OFS, {2'h0, e});
        end
        $display("test random control words done");
        wr(`TBT_ODD_CTRL_OFS, 32'h0, 2'h0);
        for (i = 0; i < 8; i++)
        begin
            wr(`TBT_EVEN_CTRL_OFS, 32'h8000 | (i << 4), 2'h0);
            span((i == 7) ? 1024 : (4 << i), 16'h0004);
            wr(`TBT_EVEN_CTRL_OFS, 32'h0, 2'h0);
            // quiet cycles after switching off before the next access
            span(8, 16'h0000);
        end
        $display("test prescaler done");
        wr(`TBT_EVEN_CTRL_OFS, 32'h0000a000, 2'h0);
        idle <= 1'h1;
        span(10, 16'h0000);
        idle <= 1'h0;
        span(10, 16'h000a);
        wr(`TBT_EVEN_CTRL_OFS, 32'h00008000, 2'h0);
        idle <= 1'h1;
        span(10, 16'h000a);
        idle <= 1'h0;
        wr(`TBT_EVEN_CTRL_OFS, 32'h00008080, 2'h0);
        span(10, 16'h0000);
        eg <= 1'h1;
        span(10, 16'h000a);
        $display("test idle and gate done");
        // gate low and internal ticks must both be ignored on the pin clock
        eg <= 1'h0;
        og <= 1'h0;
        wr(`TBT_EVEN_CTRL_OFS, 32'h00008082, 2'h0);
        wr(`TBT_ODD_CTRL_OFS, 32'h00008082, 2'h0);
        repeat (3) @(posedge aclk);
        c0 = ec;
        o0 = oc;
        repeat (8)
        begin
            ep <= 1'h1;
            op <= 1'h1;
            repeat (2) @(posedge aclk);
            ep <= 1'h0;
            op <= 1'h0;
            repeat (2) @(posedge aclk);
        end
        repeat (3) @(posedge aclk);
        chk(16'(ec - c0), 16'h0008);
        chk(16'(oc - o0), 16'h0008);
        $display("test external clock done");
        wr(`TBT_EVEN_CTRL_OFS, 32'h0, 2'h0);
        wr(`TBT_ODD_CTRL_OFS, 32'h00000070, 2'h0);
        wr(`TBT_EVEN_CTRL_OFS, 32'h00008008, 2'h0);
        repeat (3) @(posedge aclk);
        o0 = oc;
        for (i = 0; i < 70000 && ec !== 16'hffff; i++) @(posedge aclk);
        if (i == 70000) fail;
        chk(oc, o0);
        repeat (3) @(posedge aclk);
        chk(oc, 16'(o0 + 16'h0001));
        $display("test paired mode done");
        stop_test;
    end
endmodule
